/* File: core/ces_pkg.sv */
/*
  constants, register map and state type of the cpu exception sequencer.
  assumes one clock, an apb register port and an acked memory port.
*/
// Contract
// RQ1: reset vectors sit at vector number times four, base register ignored.
// RQ2: other exceptions fetch from vector base plus vector number times four.
// RQ3: reset release with nmi high starts power-on reset; reset beats everything.
// RQ4: reset release with nmi low starts manual reset.
// RQ5: manual reset spares bus control, pin function and io ports.
// RQ6: outside party holds reset low at least 20 clock cycles.
// RQ7: reset reads pc then sp, clears vector base, mask all ones.
// RQ8: manual reset runs the same sequence from its own vector entries.
// RQ9: manual reset keeps refresh alive and lets a running bus cycle finish.
// RQ10: instruction fetch from an odd address is an address error.
// RQ11: instruction fetch from peripheral register space is an address error.
// RQ12: word access at an odd address by cpu or dma errs.
// RQ13: long access not on a four byte boundary errs.
// RQ14: long access to 8-bit peripheral regions errs; 16-bit regions fine.
// RQ15: address error handling waits for bus cycle and instruction end.
// RQ16: address error pushes status word, then next pc, then jumps.
// RQ17: sources are nmi, user break, eight pins, peripheral requests.
// RQ18: nmi has level 16 and is always accepted.
// RQ19: user break has fixed level 15.
// RQ20: pins and peripherals carry programmable levels 0 to 15.
// RQ21: of several pending interrupts the highest level is taken.
// RQ22: maskable interrupt taken only when level exceeds mask.
// RQ23: interrupt pushes status and pc, mask gets level, 15 for nmi.
// RQ24: stacking uses general register 15, status word first.
// RQ25: every vector read is one aligned 32-bit read used whole.
package ces_pkg;

   // vector numbers
   localparam logic [7:0]  VEC_POR_PC   = 8'h00;
   localparam logic [7:0]  VEC_MR_PC    = 8'h02;
   localparam logic [7:0]  VEC_CPU_AE   = 8'h09;
   localparam logic [7:0]  VEC_DMA_AE   = 8'h0a;
   localparam logic [7:0]  VEC_NMI      = 8'h0b;
   localparam logic [7:0]  VEC_UBRK     = 8'h0c;
   localparam logic [7:0]  VEC_IRQ0     = 8'h40;

   // priority levels and mask values
   localparam logic [4:0]  LVL_NMI      = 5'h10;
   localparam logic [4:0]  LVL_UBRK     = 5'h0f;
   localparam logic [3:0]  MASK_NMI     = 4'hf;
   localparam logic [3:0]  MASK_RESET   = 4'hf;
   localparam int unsigned MASK_LSB     = 4;
   localparam int unsigned N_IRQ        = 8;

   // reset values and stacking step
   localparam logic [31:0] VBR_RESET    = 32'h0000_0000;
   localparam logic [31:0] SR_RESET     = 32'h0000_00f0;
   localparam logic [31:0] PRIO_RESET   = 32'h0000_0000;
   localparam logic [31:0] WORD_STEP    = 32'h0000_0004;

   // peripheral register space bounds (inclusive)
   localparam logic [31:0] PERIPH_LO    = 32'h05ff_fe00;
   localparam logic [31:0] PERIPH_HI    = 32'h05ff_ffff;

   // access size codes
   localparam logic [1:0]  SZ_BYTE      = 2'h0;
   localparam logic [1:0]  SZ_WORD      = 2'h1;
   localparam logic [1:0]  SZ_LONG      = 2'h2;

   // apb register byte offsets
   localparam logic [7:0]  REG_VBR      = 8'h00;
   localparam logic [7:0]  REG_SR       = 8'h04;
   localparam logic [7:0]  REG_PRIO     = 8'h08;
   localparam logic [7:0]  REG_GR15     = 8'h0c;
   localparam logic [7:0]  REG_PC       = 8'h10;
   localparam logic [7:0]  REG_STAT     = 8'h14;
   localparam logic [7:0]  REG_ERRADR   = 8'h18;

   // status register field positions
   localparam int unsigned ST_POR_BIT   = 4;
   localparam int unsigned ST_AEC_BIT   = 5;
   localparam int unsigned ST_AED_BIT   = 6;
   localparam int unsigned ST_NMI_BIT   = 7;
   localparam int unsigned ST_VEC_LSB   = 8;

   typedef enum logic [3:0] {
      ST_HOLD,
      ST_RD_PC,
      ST_RD_SP,
      ST_RUN,
      ST_PUSH_SR,
      ST_PUSH_PC,
      ST_RD_VEC
   } ces_state_type;

endpackage

/* File: core/ces_top.sv */
/*
  cpu exception sequencer: reset sequencing, address error detection,
  interrupt arbitration, stacking and vector fetch.
  assumes the cpu core reports instruction boundaries and its next pc,
  bus masters report every access in the cycle they issue it, and the
  memory port answers each request with a one-cycle mem_ack.
*/
`timescale 1ns/10ps
module ces_top
   import ces_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        chip_init_pin_n,
   input  wire logic        nmi_pin,
   input  wire logic [7:0]  external_irq_pins,
   input  wire logic        user_break_req,
   input  wire logic        periph_irq_req,
   input  wire logic [3:0]  periph_irq_level,
   input  wire logic [7:0]  periph_irq_vector,
   output logic             periph_irq_ack,
   input  wire logic        insn_boundary,
   input  wire logic        bus_idle,
   input  wire logic [31:0] cpu_next_pc,
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_addr,
   input  wire logic        data_valid,
   input  wire logic        data_is_dma,
   input  wire logic [31:0] data_addr,
   input  wire logic [1:0]  data_size,
   input  wire logic        data_region_8bit,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             cpu_run,
   output logic             pc_load,
   output logic [31:0]      program_counter,
   output logic [31:0]      general_register_15,
   output logic             periph_rst_n,
   output logic             bus_ctl_rst_n
);

   ces_state_type state_q;
   logic [9:0]    sync1_q;
   logic [9:0]    sync2_q;
   logic          init_prev_q;
   logic          nmi_prev_q;
   logic          por_q;
   logic [31:0]   vbr_q;
   logic [31:0]   sr_q;
   logic [31:0]   prio_q;
   logic [31:0]   gr15_q;
   logic [31:0]   pc_q;
   logic [31:0]   pc_tmp_q;
   logic [31:0]   saved_pc_q;
   logic [7:0]    vec_q;
   logic [3:0]    new_mask_q;
   logic          set_mask_q;
   logic          ack_sel_q;
   logic          ae_cpu_q;
   logic          ae_dma_q;
   logic          nmi_pend_q;
   logic [31:0]   err_addr_q;
   logic          req_q;
   logic          we_q;
   logic [31:0]   addr_q;
   logic [31:0]   wdata_q;
   logic          pc_load_q;
   logic          irq_ack_q;
   logic [31:0]   prdata_q;
   logic          pslverr_q;

   // synchronised pins: {reset pin, nmi, irq pins}
   wire           init_s = sync2_q[9];
   wire           nmi_s  = sync2_q[8];
   wire [7:0]     irq_s  = sync2_q[7:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 10'h000;
         sync2_q <= 10'h000;
      end else begin
         sync1_q <= {chip_init_pin_n, nmi_pin, external_irq_pins};
         sync2_q <= sync1_q;
      end
   end

   // reset pin release and nmi edge detection
   wire init_rise  = init_s & ~init_prev_q;
   wire nmi_edge   = nmi_s & ~nmi_prev_q;
   wire in_hold    = ~init_s;
   wire [3:0] mask = sr_q[MASK_LSB +: 4];

   // address error checks on fetches and data accesses
   wire in_periph_f = (fetch_addr >= PERIPH_LO) && (fetch_addr <= PERIPH_HI);
   wire in_periph_d = (data_addr >= PERIPH_LO) && (data_addr <= PERIPH_HI);
   wire fetch_err   = fetch_valid & (fetch_addr[0]              // [RQ10]
                                     | in_periph_f);            // [RQ11]
   wire word_err    = (data_size == SZ_WORD) & data_addr[0];    // [RQ12]
   wire long_err    = (data_size == SZ_LONG)
                      & ((data_addr[1:0] != 2'h0)               // [RQ13]
                         | (in_periph_d & data_region_8bit));   // [RQ14]
   wire data_err    = data_valid & (word_err | long_err);
   wire cpu_err     = fetch_err | (data_err & ~data_is_dma);
   wire dma_err     = data_err & data_is_dma;

   // interrupt arbitration over all sources
   logic [4:0] best_lvl;
   logic [7:0] best_vec;
   logic       best_found;
   logic       best_periph;
   always_comb begin
      best_lvl    = {1'b0, mask};                               // [RQ22]
      best_vec    = 8'h00;
      best_found  = 1'b0;
      best_periph = 1'b0;
      for (int i = 0; i < N_IRQ; i++) begin
         if (irq_s[i] && ({1'b0, prio_q[4*i +: 4]} > best_lvl)) begin // [RQ20] [RQ21]
            best_lvl    = {1'b0, prio_q[4*i +: 4]};
            best_vec    = VEC_IRQ0 + 8'(i);
            best_found  = 1'b1;
         end
      end
      if (periph_irq_req && ({1'b0, periph_irq_level} > best_lvl)) begin // [RQ20]
         best_lvl    = {1'b0, periph_irq_level};
         best_vec    = periph_irq_vector;
         best_found  = 1'b1;
         best_periph = 1'b1;
      end
      if (user_break_req && (LVL_UBRK > best_lvl)) begin        // [RQ19]
         best_lvl    = LVL_UBRK;
         best_vec    = VEC_UBRK;
         best_found  = 1'b1;
         best_periph = 1'b0;
      end
      if (nmi_pend_q) begin                                     // [RQ18]
         best_lvl    = LVL_NMI;
         best_vec    = VEC_NMI;
         best_found  = 1'b1;
         best_periph = 1'b0;
      end
   end

   // acceptance only at an instruction end with the bus quiet
   wire at_boundary = (state_q == ST_RUN) & init_s & insn_boundary & bus_idle; // [RQ15]
   wire take_ae     = at_boundary & (ae_cpu_q | ae_dma_q);
   wire take_cpu_ae = take_ae & ae_cpu_q;
   wire take_irq    = at_boundary & ~take_ae & best_found;
   wire take_nmi    = take_irq & (best_lvl == LVL_NMI);
   wire [3:0] irq_mask = take_nmi ? MASK_NMI : best_lvl[3:0];    // [RQ23]
   wire [7:0] exc_vec  = take_ae ? (take_cpu_ae ? VEC_CPU_AE : VEC_DMA_AE) : best_vec;

   // vector table addresses
   wire [7:0]  rst_vec    = (nmi_s ? VEC_POR_PC : VEC_MR_PC);
   wire [31:0] rst_pc_adr = {22'h0, rst_vec, 2'h0};             // [RQ1]
   wire [31:0] exc_adr    = vbr_q + {22'h0, vec_q, 2'h0};       // [RQ2]
   wire [31:0] gr15_dec   = gr15_q - WORD_STEP;                 // [RQ24]

   // apb decode
   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pwrite;
   wire hit_vbr   = (paddr == REG_VBR);
   wire hit_sr    = (paddr == REG_SR);
   wire hit_prio  = (paddr == REG_PRIO);
   wire hit_gr15  = (paddr == REG_GR15);
   wire hit_pc    = (paddr == REG_PC);
   wire hit_stat  = (paddr == REG_STAT);
   wire hit_err   = (paddr == REG_ERRADR);
   wire hit_any   = hit_vbr | hit_sr | hit_prio | hit_gr15 | hit_pc | hit_stat | hit_err;
   wire [31:0] stat_word = {16'h0, vec_q, nmi_pend_q, ae_dma_q, ae_cpu_q, por_q,
                            4'(state_q)};
   wire [31:0] rd_mux = hit_vbr  ? vbr_q  :
                        hit_sr   ? sr_q   :
                        hit_prio ? prio_q :
                        hit_gr15 ? gr15_q :
                        hit_pc   ? pc_q   :
                        hit_stat ? stat_word :
                        hit_err  ? err_addr_q : 32'h0000_0000;

   // apb read data and error taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         prdata_q  <= rd_mux;
         pslverr_q <= ~hit_any;
      end
   end

   // pending flags: a new event beats the clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ae_cpu_q    <= 1'b0;
         ae_dma_q    <= 1'b0;
         nmi_pend_q  <= 1'b0;
         err_addr_q  <= 32'h0000_0000;
         init_prev_q <= 1'b0;
         nmi_prev_q  <= 1'b0;
      end else begin
         init_prev_q <= init_s;
         nmi_prev_q  <= nmi_s;
         ae_cpu_q    <= ~in_hold & (cpu_err | (ae_cpu_q & ~take_cpu_ae));
         ae_dma_q    <= ~in_hold & (dma_err | (ae_dma_q & ~(take_ae & ~ae_cpu_q)));
         nmi_pend_q  <= ~in_hold & (nmi_edge | (nmi_pend_q & ~take_nmi)); // [RQ17]
         if (cpu_err | dma_err) begin
            err_addr_q <= fetch_err ? fetch_addr : data_addr;
         end
      end
   end

   // exception sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ST_HOLD;
         por_q      <= 1'b1;
         vbr_q      <= VBR_RESET;
         sr_q       <= SR_RESET;
         prio_q     <= PRIO_RESET;
         gr15_q     <= 32'h0000_0000;
         pc_q       <= 32'h0000_0000;
         pc_tmp_q   <= 32'h0000_0000;
         saved_pc_q <= 32'h0000_0000;
         vec_q      <= 8'h00;
         new_mask_q <= 4'h0;
         set_mask_q <= 1'b0;
         ack_sel_q  <= 1'b0;
         req_q      <= 1'b0;
         we_q       <= 1'b0;
         addr_q     <= 32'h0000_0000;
         wdata_q    <= 32'h0000_0000;
         pc_load_q  <= 1'b0;
         irq_ack_q  <= 1'b0;
      end else begin
         pc_load_q <= 1'b0;
         irq_ack_q <= 1'b0;
         // software writes; sequencer updates below take precedence
         if (apb_wr && hit_vbr) begin
            vbr_q <= pwdata;
         end
         if (apb_wr && hit_sr) begin
            sr_q <= pwdata;
         end
         if (apb_wr && hit_prio) begin
            prio_q <= pwdata;
         end
         if (apb_wr && hit_gr15) begin
            gr15_q <= pwdata;
         end
         if (in_hold) begin                                     // [RQ3]
            state_q <= ST_HOLD;
            por_q   <= nmi_s;                                   // [RQ3] [RQ4]
            if (nmi_s || mem_ack) begin
               req_q <= 1'b0;                                   // [RQ9]
            end
            if (nmi_s) begin
               prio_q <= PRIO_RESET;                            // [RQ5]
            end
         end else begin
            case (state_q)
               ST_HOLD: begin
                  if (init_rise && !req_q) begin
                     req_q   <= 1'b1;                           // [RQ25]
                     we_q    <= 1'b0;
                     addr_q  <= rst_pc_adr;                     // [RQ7] [RQ8]
                     state_q <= ST_RD_PC;
                  end else if (mem_ack) begin
                     req_q <= 1'b0;                             // [RQ9]
                  end
               end
               ST_RD_PC: begin
                  if (mem_ack) begin
                     pc_tmp_q <= mem_rdata;                     // [RQ7]
                     addr_q   <= addr_q + WORD_STEP;
                     state_q  <= ST_RD_SP;
                  end
               end
               ST_RD_SP: begin
                  if (mem_ack) begin
                     req_q                 <= 1'b0;
                     gr15_q                <= mem_rdata;        // [RQ7]
                     pc_q                  <= pc_tmp_q;
                     vbr_q                 <= VBR_RESET;
                     sr_q[MASK_LSB +: 4]   <= MASK_RESET;
                     pc_load_q             <= 1'b1;
                     state_q               <= ST_RUN;
                  end
               end
               ST_RUN: begin
                  if (take_ae || take_irq) begin
                     vec_q      <= exc_vec;
                     new_mask_q <= irq_mask;
                     set_mask_q <= take_irq;                    // [RQ16] [RQ23]
                     ack_sel_q  <= take_irq & best_periph;
                     saved_pc_q <= cpu_next_pc;
                     gr15_q     <= gr15_dec;                    // [RQ24]
                     req_q      <= 1'b1;
                     we_q       <= 1'b1;
                     addr_q     <= gr15_dec;
                     wdata_q    <= sr_q;
                     state_q    <= ST_PUSH_SR;
                  end
               end
               ST_PUSH_SR: begin
                  if (mem_ack) begin
                     gr15_q  <= gr15_dec;                       // [RQ24]
                     addr_q  <= gr15_dec;
                     wdata_q <= saved_pc_q;                     // [RQ16]
                     state_q <= ST_PUSH_PC;
                  end
               end
               ST_PUSH_PC: begin
                  if (mem_ack) begin
                     if (set_mask_q) begin
                        sr_q[MASK_LSB +: 4] <= new_mask_q;      // [RQ23]
                     end
                     irq_ack_q <= ack_sel_q;
                     we_q      <= 1'b0;
                     addr_q    <= exc_adr;                      // [RQ2] [RQ25]
                     state_q   <= ST_RD_VEC;
                  end
               end
               ST_RD_VEC: begin
                  if (mem_ack) begin
                     req_q     <= 1'b0;
                     pc_q      <= mem_rdata;                    // [RQ16] [RQ25]
                     pc_load_q <= 1'b1;
                     state_q   <= ST_RUN;
                  end
               end
               default: begin
                  req_q   <= 1'b0;
                  state_q <= ST_HOLD;
               end
            endcase
         end
      end
   end

   // outputs
   assign pready              = 1'b1;
   assign prdata              = prdata_q;
   assign pslverr             = pslverr_q;
   assign mem_req             = req_q;
   assign mem_we              = we_q;
   assign mem_addr            = addr_q;
   assign mem_wdata           = wdata_q;
   assign cpu_run             = (state_q == ST_RUN) & init_s;
   assign pc_load             = pc_load_q;
   assign program_counter     = pc_q;
   assign general_register_15 = gr15_q;
   assign periph_irq_ack      = irq_ack_q;
   assign periph_rst_n        = init_s;                          // [RQ5]
   assign bus_ctl_rst_n       = ~(in_hold & nmi_s);              // [RQ5] [RQ9]

endmodule

/* File: testbench/ces_mem_model.sv */
/* memory partner for the exception sequencer.
   assumes one request at a time, held until its one-cycle ack. */
`timescale 1ns/10ps
module ces_mem_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic        slow,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [1:0] wait_q;

   // ack after one or three cycles; data toggles when not valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q    <= 2'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0;
      end else if (mem_req && !mem_ack && wait_q == {slow, 1'b0}) begin
         wait_q    <= 2'h0;
         mem_ack   <= 1'b1;
         mem_rdata <= 32'h0001_0000 ^ (mem_addr << 4);
      end else begin
         wait_q    <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

/* File: testbench/ces_top_checker.sv */
/* port assertions of the exception sequencer.
   assumes binding to ces_top and a quiet memory port at reset pin edges. */
`timescale 1ns/10ps
module ces_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        chip_init_pin_n,
   input wire logic        nmi_pin,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic        cpu_run,
   input wire logic        pc_load,
   input wire logic [31:0] program_counter,
   input wire logic [31:0] general_register_15,
   input wire logic        periph_irq_ack,
   input wire logic        periph_rst_n,
   input wire logic        bus_ctl_rst_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_reset_vector : assert property (
      $rose(chip_init_pin_n) |-> ##[2:4] (mem_req && mem_addr == (nmi_pin ? 32'h0 : 32'h8)))
      else $error("reset vector read misplaced");
   chk_load_value : assert property (
      pc_load |-> $past(mem_ack) && (program_counter == $past(mem_rdata)
         || general_register_15 == $past(mem_rdata)))
      else $error("load not vector word");
   chk_req_hold : assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request changed before ack");
   chk_word_align : assert property (
      mem_req |-> mem_addr[1:0] == 2'h0)
      else $error("access not aligned");
   chk_first_push : assert property (
      $fell(cpu_run) && mem_req |-> mem_we && mem_addr == general_register_15)
      else $error("first push misplaced");
   chk_ack_pulse : assert property (
      periph_irq_ack |-> !cpu_run ##1 !periph_irq_ack)
      else $error("ack not one pulse");
   chk_init_outs : assert property (
      !chip_init_pin_n [*5] |-> !periph_rst_n && !cpu_run && !pc_load)
      else $error("reset pin low but core not held");
   chk_keep_bus : assert property (
      (!chip_init_pin_n && !nmi_pin) [*5] |-> bus_ctl_rst_n)
      else $error("manual reset touched bus control");
endmodule

bind ces_top ces_checker u_chk (.*);

/* File: testbench/test_cpu_exception_sequencer.sv */
/* self-checking bench of the exception sequencer.
   assumes ces_top, ces_mem_model and the bound checker. */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module test_cpu_exception_sequencer
   import ces_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
   logic        chip_init_pin_n, nmi_pin, user_break_req, periph_irq_req, periph_irq_ack;
   logic        insn_boundary, bus_idle, fetch_valid, data_valid, data_is_dma;
   logic        data_region_8bit, mem_req, mem_we, mem_ack, cpu_run, pc_load;
   logic        periph_rst_n, bus_ctl_rst_n;
   logic [7:0]  paddr, external_irq_pins, periph_irq_vector;
   logic [3:0]  periph_irq_level;
   logic [1:0]  data_size;
   logic [31:0] pwdata, prdata, rd, cpu_next_pc, fetch_addr, data_addr, mem_addr;
   logic [31:0] mem_wdata, mem_rdata, program_counter, general_register_15;
   logic [63:0] log_q[$];
   int          n_mismatch, tests_run;
   // kind, size, 8-bit region, expected dma/cpu pending, address
   localparam logic [38:0] AE_TAB [12] = '{
      {2'h0, SZ_WORD, 1'h0, 2'h1, 32'h1001}, {2'h0, SZ_WORD, 1'h0, 2'h0, 32'h1002},
      {2'h0, SZ_WORD, 1'h0, 2'h1, PERIPH_LO}, {2'h1, SZ_WORD, 1'h0, 2'h1, 32'h2003},
      {2'h1, SZ_WORD, 1'h0, 2'h0, 32'h2002}, {2'h1, SZ_LONG, 1'h0, 2'h1, 32'h2002},
      {2'h1, SZ_LONG, 1'h0, 2'h0, 32'h2004}, {2'h2, SZ_WORD, 1'h0, 2'h2, 32'h2001},
      {2'h2, SZ_LONG, 1'h0, 2'h2, 32'h2006}, {2'h1, SZ_BYTE, 1'h1, 2'h0, PERIPH_LO + 1},
      {2'h1, SZ_LONG, 1'h0, 2'h0, PERIPH_HI - 3}, {2'h2, SZ_LONG, 1'h1, 2'h2, PERIPH_LO + 4}};

   ces_top u_dut (.*);
   ces_mem_model u_mem (.*);

   // clock and a log of completed memory transfers
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) if (mem_req === 1'b1 && mem_ack === 1'b1)
      log_q.push_back({mem_addr, mem_wdata});

   function automatic logic [31:0] word_at(input logic [31:0] a);
      return 32'h0001_0000 ^ (a << 4);
   endfunction
   function automatic logic [31:0] vaddr(input logic [7:0] v);
      return 32'h0000_0400 + {22'h0, v, 2'h0};
   endfunction

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic give_up;
      n_mismatch++;
      end_of_test();
   endtask

   // one apb transfer, waiting for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) give_up();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_load;
      int k;
      for (k = 0; k < 300; k++) begin
         @(posedge pclk);
         if (pc_load === 1'b1) break;
      end
      if (k == 300) give_up();
   endtask
   task automatic mask_is(input logic [3:0] e);
      apb(1'b0, REG_SR, 32'h0);
      `CHK("irq mask", e, rd[7:4])
   endtask

   // reset pin low past the minimum, then the two vector reads
   task automatic do_reset(input logic nmi, input logic [31:0] base);
      nmi_pin <= nmi;
      chip_init_pin_n <= 1'b0;
      repeat (22) @(posedge pclk);
      chip_init_pin_n <= 1'b1;
      log_q.delete();
      wait_load();
      `CHK("pc entry", base, log_q[0][63:32])
      `CHK("sp entry", base + 32'h4, log_q[1][63:32])
      `CHK("initial pc", word_at(base), program_counter)
      `CHK("initial sp", word_at(base + 32'h4), general_register_15)
      apb(1'b0, REG_VBR, 32'h0);
      `CHK("vbr", 32'h0, rd)
      mask_is(MASK_RESET);
   endtask

   // stacking then the vector read
   task automatic exc(input logic [31:0] va);
      logic [31:0] sp;
      sp = general_register_15;
      log_q.delete();
      wait_load();
      `CHK("push sr at", sp - 32'h4, log_q[0][63:32])
      `CHK("push pc", {sp - 32'h8, cpu_next_pc}, log_q[1])
      `CHK("vector at", va, log_q[2][63:32])
      `CHK("handler", word_at(va), program_counter)
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, slow, user_break_req} = '0;
      {periph_irq_req, periph_irq_level, periph_irq_vector, external_irq_pins} = '0;
      {fetch_valid, fetch_addr, data_valid, data_is_dma, data_addr} = '0;
      {data_size, data_region_8bit, presetn, chip_init_pin_n} = '0;
      {nmi_pin, insn_boundary, bus_idle} = 3'h7;
      cpu_next_pc = 32'h0000_2222;
      n_mismatch = 0;
      tests_run = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      do_reset(1'b1, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK("unmapped", 1'b1, err)
      $display("power-on reset done");
      // address error table with a slow memory
      apb(1'b1, REG_VBR, 32'h400);
      slow <= 1'b1;
      foreach (AE_TAB[i]) begin
         @(posedge pclk);
         insn_boundary <= 1'b0;
         fetch_valid <= AE_TAB[i][38:37] == 2'h0;
         data_valid <= AE_TAB[i][38:37] != 2'h0;
         data_is_dma <= AE_TAB[i][38];
         data_size <= AE_TAB[i][36:35];
         data_region_8bit <= AE_TAB[i][34];
         fetch_addr <= AE_TAB[i][31:0];
         data_addr <= AE_TAB[i][31:0];
         @(posedge pclk);
         fetch_valid <= 1'b0;
         data_valid <= 1'b0;
         apb(1'b0, REG_STAT, 32'h0);
         `CHK("pending", AE_TAB[i][33:32], rd[6:5])
         insn_boundary <= 1'b1;
         if (AE_TAB[i][33]) exc(vaddr(VEC_DMA_AE));
         else if (AE_TAB[i][32]) exc(vaddr(VEC_CPU_AE));
      end
      mask_is(MASK_RESET);
      $display("address errors done");
      // equal level refused, higher accepted
      slow <= 1'b0;
      nmi_pin <= 1'b0;
      apb(1'b1, REG_SR, 32'h50);
      apb(1'b1, REG_PRIO, 32'h500);
      external_irq_pins <= 8'h04;
      log_q.delete();
      repeat (12) @(posedge pclk);
      `CHK("equal level", 0, log_q.size())
      apb(1'b1, REG_PRIO, 32'h600);
      exc(vaddr(VEC_IRQ0 + 8'h2));
      mask_is(4'h6);
      // several pending: highest level first
      insn_boundary <= 1'b0;
      external_irq_pins <= 8'h0a;
      apb(1'b1, REG_PRIO, 32'h9070);
      periph_irq_level <= 4'h8;
      periph_irq_vector <= 8'h50;
      periph_irq_req <= 1'b1;
      repeat (4) @(posedge pclk);
      insn_boundary <= 1'b1;
      exc(vaddr(VEC_IRQ0 + 8'h3));
      mask_is(4'h9);
      external_irq_pins <= 8'h02;
      apb(1'b1, REG_SR, 32'h70);
      exc(vaddr(8'h50));
      mask_is(4'h8);
      {periph_irq_req, external_irq_pins} <= '0;
      $display("maskable interrupts done");
      // user break at level 15, then nmi over a full mask
      apb(1'b1, REG_SR, 32'he0);
      user_break_req <= 1'b1;
      exc(vaddr(VEC_UBRK));
      mask_is(4'hf);
      user_break_req <= 1'b0;
      nmi_pin <= 1'b1;
      exc(vaddr(VEC_NMI));
      mask_is(MASK_NMI);
      $display("fixed level interrupts done");
      do_reset(1'b0, 32'h8);
      $display("manual reset done");
      end_of_test();
   end
endmodule
